// File: hw/pric_top.sv
// Prioritized interrupt controller: flags, enables, priorities, arbiter, vector delivery
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`include "pric_defines.svh"
// Notes on behaviour
// (R01) Arbitrates 41 request sources plus 4 trap sources, winner goes to core.
// (R02) Request flags set by source events, cleared only by software writes.
// (R03) Flags set on every event whatever the enable bit says.
// (R04) Software should clear a flag before enabling its source.
// (R05) Each enable bit gates its own flag into arbitration.
// (R06) Priority is 3 bits in low bits of a nibble; bit 3 reads zero.
// (R07) Levels 1 to 7 are maskable, 7 highest, 1 lowest.
// (R08) Priority zero means the source is never presented.
// (R09) Core level is 4 bits: top bit in control reg, low three in status.
// (R10) On selection, vector number and new level latch into winner status.
// (R11) Nesting disable blocks new source interrupts, though not traps, while one is in service.
// (R12) While nesting disable is set, core level writes are ignored.
// (R13) Timed disable blocks levels 6 and below; status bit 14 set meanwhile.
// (R14) Ext control reg sets pin edge behaviour and alternate vector table.
// (R15) Vector word from program data bus loads 24-bit program counter.
// (R16) Sixty-three vectors live between 0x000004 and 0x0000FE.
// (R17) Normal fetch of a vector-area word raises an address error trap.
// (R18) Equal user priority ties go to the earlier vector.
// (R19) Natural rank equals interrupt number, 0 highest.
// (R20) Present only when priority strictly exceeds the core level.
module pric_top #(
  parameter int NUM_SRC = `PRIC_NUM_SRC,
  parameter int TIMED_DIS_W = `PRIC_TIMED_DIS_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pric_pkg::pric_bus_req_t bus_req,
  output pric_pkg::pric_bus_rsp_t bus_rsp,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [`PRIC_NUM_EXT-1:0] ext_irq_pin,
  input wire logic [`PRIC_NUM_TRAP-1:0] trap_event,
  input wire logic timed_disable_start,
  input wire logic [TIMED_DIS_W-1:0] timed_disable_count,
  input wire logic instr_retire,
  input wire logic irq_ack,
  input wire logic service_done,
  input wire logic [3:0] restore_level,
  input wire logic prog_valid,
  input wire logic [23:0] prog_data,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_addr,
  output logic irq_request,
  output pric_pkg::pric_winner_t irq_winner,
  output logic vec_fetch_req,
  output logic [23:0] vec_fetch_addr,
  output logic pc_load,
  output logic [23:0] pc_load_addr,
  output logic [3:0] core_priority_level
);
  import pric_pkg::*;

  localparam int FLAG_W = 48;
  localparam int EXT_SRC [`PRIC_NUM_EXT] = `PRIC_EXT_SRC_LIST;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] irq_flags, next_irq_flags;
  logic [FLAG_W-1:0] irq_enables, next_irq_enables;
  logic [2:0] source_priority_field [NUM_SRC];
  logic [2:0] next_source_priority_field [NUM_SRC];
  logic [15:0] irq_control_trap, next_irq_control_trap;
  logic [15:0] irq_control_ext, next_irq_control_ext;
  logic [TIMED_DIS_W-1:0] timed_disable, next_timed_disable;
  logic [5:0] service_depth, next_service_depth;
  logic [`PRIC_NUM_EXT-1:0] ext_prev, next_ext_prev;
  logic bus_ack, next_bus_ack;
  pric_state_t state, next_state;
  pric_bus_rsp_t next_bus_rsp;
  pric_winner_t next_irq_winner;
  logic next_irq_request, next_vec_fetch_req, next_pc_load;
  logic [23:0] next_vec_fetch_addr, next_pc_load_addr;
  logic [3:0] next_core_priority_level;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // One 16-bit bank of a flat flag or enable vector
  function automatic logic [15:0] bank_word(input logic [FLAG_W-1:0] v, input int idx);
    bank_word = v[idx*16 +: 16];
  endfunction

  // Apply byte enables to the low half-word of a write
  function automatic logic [15:0] merge_be(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    merge_be = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Read image of one priority register: four nibbles, top nibble bit zero
  function automatic logic [15:0] prio_word(input int reg_idx);
    logic [15:0] w;
    w = 16'h0000;
    for (int n = 0; n < 4; n++)
      if (reg_idx * 4 + n < NUM_SRC)
        w[n*4 +: 3] = source_priority_field[reg_idx*4 + n]; // R06
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Arbiter: traps first, then highest level, ties to lowest number
  // ----------------------------------------------------------------
  logic cand_valid;
  logic cand_trap;
  pric_winner_t cand;
  logic [NUM_SRC-1:0] src_live;

  always_comb
  begin
    cand_valid = 1'b0;
    cand_trap = 1'b0;
    cand = '0;
    for (int s = 0; s < NUM_SRC; s++)
      src_live[s] = irq_flags[s] && irq_enables[s] && source_priority_field[s] != 3'h0; // R05 R08
    // Ascending scan with strict compare keeps the lower number on a tie
    for (int s = 0; s < NUM_SRC; s++)
    begin
      if (src_live[s] && (!cand_valid || {1'b0, source_priority_field[s]} > cand.level)) // R18 R19
      begin
        cand_valid = 1'b1;
        cand.level = {1'b0, source_priority_field[s]}; // R07
        cand.vector = `PRIC_VEC_SRC_BASE + 6'(s);
      end
    end
    // Traps sit above all maskable levels, trap 0 highest
    for (int t = `PRIC_NUM_TRAP - 1; t >= 0; t--)
    begin
      if (irq_control_trap[t]) // R01
      begin
        cand_valid = 1'b1;
        cand_trap = 1'b1;
        cand.level = `PRIC_TRAP_LEVEL_TOP - 4'(t);
        cand.vector = `PRIC_VEC_TRAP_BASE + 6'(t);
      end
    end
  end

  // Presentation gate: above core level, nesting and timed blocking
  logic present_ok;
  always_comb
  begin
    present_ok = cand_valid && cand.level > core_priority_level; // R20
    if (irq_control_trap[`PRIC_BIT_NEST_DIS] && service_depth != 6'h00 && !cand_trap)
      present_ok = 1'b0; // R11
    if (timed_disable != '0 && cand.level <= `PRIC_TIMED_DIS_MAX_LVL)
      present_ok = 1'b0; // R13
  end

  // ----------------------------------------------------------------
  // Source events: peripheral strobes plus external pin edges
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] set_events;
  logic [`PRIC_NUM_TRAP-1:0] trap_set;
  logic guard_hit;
  logic accept;

  always_comb
  begin
    set_events = '0;
    set_events[NUM_SRC-1:0] = src_event; // R03
    // Control bit low selects rising edge, high selects falling edge
    for (int e = 0; e < `PRIC_NUM_EXT; e++)
      if (irq_control_ext[e] ? (ext_prev[e] && !ext_irq_pin[e])
                             : (!ext_prev[e] && ext_irq_pin[e])) // R14
        set_events[EXT_SRC[e]] = 1'b1;
    guard_hit = fetch_valid && fetch_addr >= `PRIC_GUARD_LO
                && fetch_addr <= `PRIC_GUARD_HI; // R16 R17
    trap_set = trap_event;
    trap_set[`PRIC_TRAP_ADDR_ERR] = trap_event[`PRIC_TRAP_ADDR_ERR] || guard_hit; // R17
    accept = irq_ack && state == PRIC_ST_IDLE && present_ok;
  end

  // ----------------------------------------------------------------
  // Next-state logic: bus slave, registers, vector delivery
  // ----------------------------------------------------------------
  logic wr_now;
  logic rd_now;
  logic [7:0] addr;
  logic [15:0] rd_word;

  always_comb
  begin
    addr = bus_req.address;
    wr_now = bus_req.write && bus_ack;
    rd_now = bus_req.read && !bus_ack;
    next_bus_ack = (bus_req.read || bus_req.write) && !bus_ack;
    next_irq_flags = irq_flags;
    next_irq_enables = irq_enables;
    next_source_priority_field = source_priority_field;
    next_irq_control_trap = irq_control_trap;
    next_irq_control_ext = irq_control_ext;
    next_core_priority_level = core_priority_level;
    next_irq_winner = irq_winner;
    next_timed_disable = timed_disable;
    next_service_depth = service_depth;
    next_ext_prev = ext_irq_pin;
    next_state = state;
    next_vec_fetch_req = vec_fetch_req;
    next_vec_fetch_addr = vec_fetch_addr;
    next_pc_load = 1'b0;
    next_pc_load_addr = pc_load_addr;
    rd_word = 16'h0000;

    // Register writes take effect one edge after the edge that ends waitrequest
    if (wr_now)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (addr == `PRIC_OFF_FLAGS0 + 8'(b * 4))
          next_irq_flags[b*16 +: 16] = merge_be(bank_word(irq_flags, b),
                                                bus_req.writedata, bus_req.byteenable); // R02
        if (addr == `PRIC_OFF_ENABLES0 + 8'(b * 4))
          next_irq_enables[b*16 +: 16] = merge_be(bank_word(irq_enables, b),
                                                  bus_req.writedata, bus_req.byteenable);
      end
      for (int r = 0; r < `PRIC_NUM_PRIO_REGS; r++)
        if (addr == `PRIC_OFF_PRIO0 + 8'(r * 4))
          for (int n = 0; n < 4; n++)
            if (r * 4 + n < NUM_SRC && bus_req.byteenable[n / 2])
              next_source_priority_field[r*4 + n] = bus_req.writedata[n*4 +: 3]; // R06
      if (addr == `PRIC_OFF_CTRL_TRAP)
        next_irq_control_trap = merge_be(irq_control_trap, bus_req.writedata,
                                         bus_req.byteenable) & `PRIC_CTRL_TRAP_WMASK;
      if (addr == `PRIC_OFF_CTRL_EXT)
        next_irq_control_ext = merge_be(irq_control_ext, bus_req.writedata,
                                        bus_req.byteenable) & `PRIC_CTRL_EXT_WMASK; // R14
      // Core level is frozen against software while nesting is disabled
      if (!irq_control_trap[`PRIC_BIT_NEST_DIS] && bus_req.byteenable[0]) // R12
      begin
        if (addr == `PRIC_OFF_CORE_CTRL)
          next_core_priority_level[3] = bus_req.writedata[`PRIC_BIT_CORE_LVL_HI]; // R09
        if (addr == `PRIC_OFF_CORE_STAT)
          next_core_priority_level[2:0] =
            bus_req.writedata[`PRIC_LSB_CORE_LVL_LO +: 3]; // R09
      end
    end

    // Hardware sets win over a software clear in the same cycle
    next_irq_flags = next_irq_flags | set_events; // R02 R03
    next_irq_control_trap[`PRIC_NUM_TRAP-1:0] =
      next_irq_control_trap[`PRIC_NUM_TRAP-1:0] | trap_set;

    // Read image, captured on the same edge that waitrequest drops
    for (int b = 0; b < 3; b++)
    begin
      if (addr == `PRIC_OFF_FLAGS0 + 8'(b * 4))
        rd_word = bank_word(irq_flags, b);
      if (addr == `PRIC_OFF_ENABLES0 + 8'(b * 4))
        rd_word = bank_word(irq_enables, b);
    end
    for (int r = 0; r < `PRIC_NUM_PRIO_REGS; r++)
      if (addr == `PRIC_OFF_PRIO0 + 8'(r * 4))
        rd_word = prio_word(r);
    if (addr == `PRIC_OFF_PRIO_LAST)
      rd_word = rd_word & `PRIC_PRIO_LAST_MASK;
    if (addr == `PRIC_OFF_WINNER)
      rd_word = {4'h0, irq_winner.level, 2'h0, irq_winner.vector}; // R10
    if (addr == `PRIC_OFF_CTRL_TRAP)
      rd_word = irq_control_trap;
    if (addr == `PRIC_OFF_CTRL_EXT)
    begin
      rd_word = irq_control_ext;
      rd_word[`PRIC_BIT_TIMED_DIS] = timed_disable != '0; // R13
    end
    if (addr == `PRIC_OFF_CORE_CTRL)
      rd_word[`PRIC_BIT_CORE_LVL_HI] = core_priority_level[3];
    if (addr == `PRIC_OFF_CORE_STAT)
      rd_word[`PRIC_LSB_CORE_LVL_LO +: 3] = core_priority_level[2:0];
    next_bus_rsp.waitrequest = !next_bus_ack;
    next_bus_rsp.readdata = rd_now ? {16'h0000, rd_word} : bus_rsp.readdata;

    // Timed disable: loaded by its instruction, counted down per retired instruction
    if (timed_disable_start)
    begin
      next_timed_disable = timed_disable_count; // R13
    end
    else if (instr_retire && timed_disable != '0)
    begin
      next_timed_disable = timed_disable - 1'b1;
    end

    // Presentation to the core
    next_irq_request = present_ok && state == PRIC_ST_IDLE && !accept; // R20

    // Vector delivery
    unique case (state)
      PRIC_ST_IDLE:
      begin
        if (accept)
        begin
          next_irq_winner = cand; // R10
          next_core_priority_level = cand.level;
          next_vec_fetch_req = 1'b1;
          next_vec_fetch_addr = (irq_control_ext[`PRIC_BIT_ALT_TABLE]
                                 ? `PRIC_ALT_TABLE_BASE : `PRIC_TABLE_BASE)
                                + {17'h00000, cand.vector, 1'b0}; // R14 R16
          next_state = PRIC_ST_FETCH;
        end
      end
      PRIC_ST_FETCH:
      begin
        if (prog_valid)
        begin
          next_vec_fetch_req = 1'b0;
          next_pc_load = 1'b1;
          next_pc_load_addr = prog_data; // R15
          next_state = PRIC_ST_IDLE;
        end
      end
    endcase

    // Nesting depth and core level restore on return
    if (accept && !service_done)
    begin
      next_service_depth = service_depth + 6'h01;
    end
    else if (service_done && !accept && service_depth != 6'h00)
    begin
      next_service_depth = service_depth - 6'h01;
    end
    if (service_done && !accept)
    begin
      next_core_priority_level = restore_level;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_flags <= '0;
      irq_enables <= '0;
      for (int s = 0; s < NUM_SRC; s++)
      begin
        source_priority_field[s] <= `PRIC_RST_PRIO;
      end
      irq_control_trap <= `PRIC_RST_WORD;
      irq_control_ext <= `PRIC_RST_WORD;
      core_priority_level <= `PRIC_RST_LEVEL;
      irq_winner <= '0;
      timed_disable <= '0;
      service_depth <= 6'h00;
      ext_prev <= '0;
      bus_ack <= 1'b0;
      bus_rsp.waitrequest <= 1'b1;
      bus_rsp.readdata <= 32'h00000000;
      state <= PRIC_ST_IDLE;
      irq_request <= 1'b0;
      vec_fetch_req <= 1'b0;
      vec_fetch_addr <= 24'h000000;
      pc_load <= 1'b0;
      pc_load_addr <= 24'h000000;
    end
    else
    begin
      irq_flags <= next_irq_flags;
      irq_enables <= next_irq_enables;
      source_priority_field <= next_source_priority_field;
      irq_control_trap <= next_irq_control_trap;
      irq_control_ext <= next_irq_control_ext;
      core_priority_level <= next_core_priority_level;
      irq_winner <= next_irq_winner;
      timed_disable <= next_timed_disable;
      service_depth <= next_service_depth;
      ext_prev <= next_ext_prev;
      bus_ack <= next_bus_ack;
      bus_rsp <= next_bus_rsp;
      state <= next_state;
      irq_request <= next_irq_request;
      vec_fetch_req <= next_vec_fetch_req;
      vec_fetch_addr <= next_vec_fetch_addr;
      pc_load <= next_pc_load;
      pc_load_addr <= next_pc_load_addr;
    end
  end

endmodule // pric_top

// File: inc/pric_defines.svh
// Constants of the prioritized interrupt controller: offsets, fields, resets, counts
`ifndef PRIC_DEFINES_SVH
`define PRIC_DEFINES_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PRIC_NUM_SRC 41
`define PRIC_NUM_TRAP 4
`define PRIC_NUM_PRIO_REGS 11
`define PRIC_TIMED_DIS_W 14

// ----------------------------------------------------------------
// Register byte offsets (32-bit word each)
// ----------------------------------------------------------------
`define PRIC_OFF_FLAGS0 8'h00
`define PRIC_OFF_ENABLES0 8'h0C
`define PRIC_OFF_PRIO0 8'h18
`define PRIC_OFF_PRIO_LAST 8'h40
`define PRIC_OFF_WINNER 8'h44
`define PRIC_OFF_CTRL_TRAP 8'h48
`define PRIC_OFF_CTRL_EXT 8'h4C
`define PRIC_OFF_CORE_CTRL 8'h50
`define PRIC_OFF_CORE_STAT 8'h54

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PRIC_BIT_NEST_DIS 15
`define PRIC_BIT_ALT_TABLE 15
`define PRIC_BIT_TIMED_DIS 14
`define PRIC_BIT_CORE_LVL_HI 3
`define PRIC_LSB_CORE_LVL_LO 5
`define PRIC_LSB_WIN_LEVEL 8
`define PRIC_CTRL_TRAP_WMASK 16'h800F
`define PRIC_CTRL_EXT_WMASK 16'h801F
`define PRIC_PRIO_LAST_MASK 16'h00FF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PRIC_RST_PRIO 3'h4
`define PRIC_RST_WORD 16'h0000
`define PRIC_RST_LEVEL 4'h0

// ----------------------------------------------------------------
// Vectors, levels and the guarded area
// ----------------------------------------------------------------
`define PRIC_VEC_SRC_BASE 6'h08
`define PRIC_VEC_TRAP_BASE 6'h01
`define PRIC_TRAP_LEVEL_TOP 4'hF
`define PRIC_TIMED_DIS_MAX_LVL 4'h6
`define PRIC_TABLE_BASE 24'h000004
`define PRIC_ALT_TABLE_BASE 24'h000084
`define PRIC_GUARD_LO 24'h000004
`define PRIC_GUARD_HI 24'h0000FE
`define PRIC_TRAP_ADDR_ERR 1

// External request pins map onto these source numbers
`define PRIC_EXT_SRC_LIST '{0, 16, 23, 36, 37}
`define PRIC_NUM_EXT 5

`endif

// File: inc/pric_pkg.sv
// Types shared by the prioritized interrupt controller and its bench
package pric_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pric_bus_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pric_bus_rsp_t;

  // Winner handed to the core
  typedef struct packed {
    logic [5:0] vector;
    logic [3:0] level;
  } pric_winner_t;

  // Vector delivery sequence
  typedef enum logic [1:0] {
    PRIC_ST_IDLE,
    PRIC_ST_FETCH
  } pric_state_t;

endpackage

// File: dv/pric_core_model.sv
// Core-side model: takes presented interrupts and returns vector words
`timescale 1ns/10ps
module pric_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] slow,
  input wire logic irq_request,
  input wire logic vec_fetch_req,
  input wire logic [23:0] vec_fetch_addr,
  output logic irq_ack,
  output logic prog_valid,
  output logic [23:0] prog_data
);
  logic [3:0] wait_cnt;

  // Ack each request once, answer a vector fetch after slow cycles
  always_ff @(posedge mclk)
  begin
    irq_ack <= !rst && irq_request && !irq_ack && !vec_fetch_req;
    prog_valid <= 1'b0;
    prog_data <= rst ? 24'h5A5A5A : ~prog_data; // Idle bus never shows a stale word
    if (rst || !vec_fetch_req || prog_valid)
      wait_cnt <= 4'h0;
    else if (wait_cnt < slow)
      wait_cnt <= wait_cnt + 4'h1;
    else
    begin
      prog_valid <= 1'b1;
      prog_data <= vec_fetch_addr ^ 24'hC00000;
    end
  end
endmodule // pric_core_model

// File: dv/pric_monitor.sv
// Port checker of the prioritized interrupt controller
`timescale 1ns/10ps
module pric_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_ack,
  input wire logic service_done,
  input wire logic [3:0] restore_level,
  input wire logic prog_valid,
  input wire logic [23:0] prog_data,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic irq_request,
  input wire pric_pkg::pric_winner_t irq_winner,
  input wire logic vec_fetch_req,
  input wire logic [23:0] vec_fetch_addr,
  input wire logic pc_load,
  input wire logic [23:0] pc_load_addr,
  input wire logic [3:0] core_priority_level
);
  import pric_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Steps of one delivery: accept, then vector word arrives
  sequence s_accept;
    irq_ack && irq_request && !vec_fetch_req;
  endsequence
  sequence s_deliver;
    vec_fetch_req && prog_valid;
  endsequence

  a_accept_fetch: assert property (s_accept |=> vec_fetch_req && !irq_request)
    else $error("accept did not start a vector fetch");
  a_new_level: assert property (s_accept |=> core_priority_level == irq_winner.level)
    else $error("core level is not the winner level");
  a_level_above: assert property (s_accept |=> irq_winner.level > $past(core_priority_level))
    else $error("winner not above core level");
  a_vector_addr: assert property ($rose(vec_fetch_req) |-> vec_fetch_addr <= 24'hFE &&
    (vec_fetch_addr - 24'({irq_winner.vector, 1'b0})) inside {24'h4, 24'h84})
    else $error("vector fetch address wrong");
  a_pc_load: assert property (s_deliver |=> pc_load && !vec_fetch_req
    && pc_load_addr == $past(prog_data))
    else $error("program counter load wrong");
  a_source_level: assert property ($rose(vec_fetch_req) && irq_winner.vector >= 6'h8
    |-> irq_winner.level inside {[4'h1:4'h7]})
    else $error("source level outside 1 to 7");
  a_restore_level: assert property (service_done |=> core_priority_level == $past(restore_level))
    else $error("core level not restored");
  a_guard_trap: assert property (fetch_valid && fetch_addr inside {[24'h4:24'hFE]}
    && core_priority_level < 4'hE && !vec_fetch_req && !irq_request |-> ##[1:6] irq_request)
    else $error("vector area fetch raised no trap");
endmodule // pric_monitor

bind pric_top pric_monitor u_mon (.mclk, .rst, .irq_ack, .service_done, .restore_level,
  .prog_valid, .prog_data, .fetch_valid, .fetch_addr, .irq_request, .irq_winner,
  .vec_fetch_req, .vec_fetch_addr, .pc_load, .pc_load_addr, .core_priority_level);

// File: dv/tb_prioritized_interrupt_controller.sv
// Self-checking bench of the prioritized interrupt controller
`timescale 1ns/10ps
module tb_prioritized_interrupt_controller;
  import pric_pkg::*;
  logic mclk, rst, timed_disable_start, instr_retire, irq_ack, service_done;
  logic prog_valid, fetch_valid, irq_request, vec_fetch_req, pc_load;
  pric_bus_req_t bus_req;
  pric_bus_rsp_t bus_rsp;
  pric_winner_t irq_winner;
  logic [40:0] src_event;
  logic [4:0] ext_irq_pin;
  logic [13:0] timed_disable_count;
  logic [3:0] restore_level, core_priority_level, slow;
  logic [23:0] prog_data, fetch_addr, vec_fetch_addr, pc_load_addr;
  logic [31:0] rd;
  int fail_count;
  int samples_checked;

  pric_top dut (.mclk, .rst, .bus_req, .bus_rsp, .src_event, .ext_irq_pin,
    .trap_event(4'h0), .timed_disable_start, .timed_disable_count, .instr_retire, .irq_ack,
    .service_done, .restore_level, .prog_valid, .prog_data, .fetch_valid, .fetch_addr,
    .irq_request, .irq_winner, .vec_fetch_req, .vec_fetch_addr, .pc_load, .pc_load_addr,
    .core_priority_level);
  pric_core_model u_core (.mclk, .rst, .slow, .irq_request, .vec_fetch_req,
    .vec_fetch_addr, .irq_ack, .prog_valid, .prog_data);

  // Clock of 4 ns
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [23:0] exp_pc(input logic [23:0] base, input logic [5:0] v);
    return (base + {v, 1'b0}) ^ 24'hC00000;
  endfunction
  function automatic int pick(input int a, input int pa, input int b, input int pb);
    if (pa != pb)
      return (pa > pb) ? a : b;
    return (a < b) ? a : b;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    bus_req <= '{read: !wr, write: wr, address: a, writedata: {16'h0, d}, byteenable: 4'hF};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (bus_rsp.waitrequest !== 1'b0 && n < 20);
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    chk("bus answer", 32'h1, 32'(n < 20));
  endtask
  // Set priority nibble, then enable bit, of one source
  task automatic arm(input int s, input logic [2:0] p);
    bus(0, 8'h18 + 8'(4 * (s / 4)), 16'h0);
    rd[4 * (s % 4) +: 4] = {1'b0, p};
    bus(1, 8'h18 + 8'(4 * (s / 4)), rd[15:0]);
    bus(0, 8'h0C + 8'(4 * (s / 16)), 16'h0);
    rd[s % 16] = 1'b1;
    bus(1, 8'h0C + 8'(4 * (s / 16)), rd[15:0]);
  endtask
  task automatic fire(input logic [40:0] m);
    @(posedge mclk);
    src_event <= m;
    @(posedge mclk);
    src_event <= '0;
  endtask
  // Wait for a delivery; vector 0 means none may come
  task automatic see(input logic [5:0] v, input logic [3:0] l, input logic [23:0] base);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pc_load !== 1'b1 && n < 40);
    if (v == 6'h0)
      chk("quiet", 32'h1, 32'(n >= 40));
    else
    begin
      chk("winner", {v, l}, irq_winner);
      chk("pc load", exp_pc(base, v), pc_load_addr);
    end
  endtask
  task automatic restart;
    @(posedge mclk);
    rst <= 1'b1;
    slow <= 4'($urandom % 8);
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    int s, a, b, pa, pb, w;
    rst = 1'b1;
    bus_req = '0;
    src_event = '0;
    ext_irq_pin = '0;
    {timed_disable_start, instr_retire, service_done, fetch_valid} = 4'h0;
    timed_disable_count = '0;
    restore_level = 4'h0;
    fetch_addr = '0;
    slow = 4'h0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(51467));
    restart;
    bus(0, 8'h18, 16'h0);
    chk("prio reset", 32'h4444, rd);
    bus(1, 8'h18, 16'hFFFF);
    bus(0, 8'h18, 16'h0);
    chk("prio mask", 32'h7777, rd);
    bus(0, 8'h80, 16'h0);
    chk("unmapped", 32'h0, rd);
    s = $urandom % 16;
    fire(41'h1 << s);
    see(0, 0, 0);
    bus(0, 8'h00, 16'h0);
    chk("flag set", 32'h1 << s, rd);
    bus(1, 8'h00, 16'h0);
    bus(0, 8'h00, 16'h0);
    chk("flag clear", 32'h0, rd);
    $display("test registers done");
    for (int r = 0; r < 6; r++)
    begin
      restart;
      a = $urandom % 41;
      b = (a + 1 + $urandom % 40) % 41;
      pa = 1 + $urandom % 7;
      pb = r[0] ? 1 + $urandom % 7 : pa;
      bus(1, 8'h00, 16'h0);
      arm(a, 3'(pa));
      arm(b, 3'(pb));
      fire((41'h1 << a) | (41'h1 << b));
      s = pick(a, pa, b, pb);
      see(6'(s + 8), 4'(s == a ? pa : pb), 24'h4);
    end
    $display("test arbitration done");
    restart;
    s = $urandom % 41;
    arm(s, 3'h0);
    fire(41'h1 << s);
    see(0, 0, 0);
    bus(1, 8'h54, 16'h00A0);
    arm(s, 3'h5);
    see(0, 0, 0);
    bus(1, 8'h50, 16'h0008);
    @(posedge mclk);
    chk("core level", 32'hD, core_priority_level);
    bus(1, 8'h50, 16'h0);
    bus(1, 8'h54, 16'h0080);
    see(6'(s + 8), 4'h5, 24'h4);
    $display("test levels done");
    restart;
    bus(1, 8'h48, 16'h8000);
    bus(1, 8'h54, 16'h0060);
    @(posedge mclk);
    chk("level locked", 32'h0, core_priority_level);
    a = $urandom % 20;
    b = a + 1 + $urandom % 20;
    arm(a, 3'h3);
    arm(b, 3'h7);
    fire(41'h1 << a);
    see(6'(a + 8), 4'h3, 24'h4);
    fire(41'h1 << b);
    see(0, 0, 0);
    @(posedge mclk);
    service_done <= 1'b1;
    @(posedge mclk);
    service_done <= 1'b0;
    see(6'(b + 8), 4'h7, 24'h4);
    $display("test nesting done");
    restart;
    s = $urandom % 41;
    w = 1 + $urandom % 5;
    @(posedge mclk);
    timed_disable_count <= 14'(w);
    timed_disable_start <= 1'b1;
    @(posedge mclk);
    timed_disable_start <= 1'b0;
    arm(s, 3'h6);
    fire(41'h1 << s);
    see(0, 0, 0);
    bus(0, 8'h4C, 16'h0);
    chk("timed on", 32'h4000, rd);
    repeat (w)
    begin
      @(posedge mclk);
      instr_retire <= 1'b1;
      @(posedge mclk);
      instr_retire <= 1'b0;
    end
    see(6'(s + 8), 4'h6, 24'h4);
    bus(0, 8'h4C, 16'h0);
    chk("timed off", 32'h0, rd);
    $display("test timed done");
    restart;
    bus(1, 8'h4C, 16'h8000);
    @(posedge mclk);
    ext_irq_pin <= 5'h02;
    fetch_valid <= 1'b1;
    fetch_addr <= 24'h000100;
    @(posedge mclk);
    fetch_valid <= 1'b0;
    see(0, 0, 0);
    bus(0, 8'h04, 16'h0);
    chk("pin flag", 32'h1, rd);
    @(posedge mclk);
    fetch_valid <= 1'b1;
    fetch_addr <= 24'h4 + 24'($urandom % 251);
    @(posedge mclk);
    fetch_valid <= 1'b0;
    see(6'h2, 4'hE, 24'h84);
    $display("test traps done");
    stop_test;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test;
  end
endmodule // tb_prioritized_interrupt_controller
